// ### common/lsh_pkg.sv
package lsh_pkg;

	// Clock rate and bus timing.
	localparam int CLK_MHZ     = 200;
	localparam int STROBE_NS   = 20;
	localparam int STROBE_CYC  = (STROBE_NS * CLK_MHZ + 999) / 1000;
	localparam int BUSY_NS     = 50;
	localparam int BUSY_CYC    = (BUSY_NS * CLK_MHZ + 999) / 1000;
	localparam int RESET_NS    = 100;
	localparam int RESET_CYC   = (RESET_NS * CLK_MHZ + 999) / 1000;

	// Memory geometry.
	localparam int COLS        = 64;
	localparam int PAGES       = 8;

	// Status byte bit positions; all other bits read as zero.
	localparam int ST_BUSY_BIT = 7;
	localparam int ST_OFF_BIT  = 5;
	localparam int ST_RST_BIT  = 4;

	// Command codes and match patterns.
	localparam logic [7:0] CMD_ON     = 8'h3F;
	localparam logic [7:0] CMD_OFF    = 8'h3E;
	localparam logic [7:0] COL_MASK   = 8'hC0;
	localparam logic [7:0] COL_CODE   = 8'h40;
	localparam logic [7:0] PAGE_MASK  = 8'hF8;
	localparam logic [7:0] PAGE_CODE  = 8'hB8;
	localparam logic [7:0] START_MASK = 8'hC0;
	localparam logic [7:0] START_CODE = 8'hC0;

	// Reset values.
	localparam logic       DISP_ON_RST = 1'h0;
	localparam logic [5:0] START_RST   = 6'h00;
	localparam logic [2:0] PAGE_RST    = 3'h0;
	localparam logic [5:0] COL_RST     = 6'h00;

	typedef enum logic [2:0] {
		CK_NONE,
		CK_DISP,
		CK_COL,
		CK_PAGE,
		CK_START
	} lsh_cmd_t;

	typedef enum logic [1:0] {
		BIAS_TOP    = 2'h0,
		BIAS_SECOND = 2'h1,
		BIAS_THIRD  = 2'h2,
		BIAS_BOTTOM = 2'h3
	} lsh_bias_t;

	// Classifies a command byte; unmatched codes give CK_NONE.
	function automatic lsh_cmd_t lsh_decode(input logic [7:0] b);
		if (b == CMD_ON || b == CMD_OFF) begin
			return CK_DISP;
		end else if ((b & COL_MASK) == COL_CODE) begin
			return CK_COL;
		end else if ((b & PAGE_MASK) == PAGE_CODE) begin
			return CK_PAGE;
		end else if ((b & START_MASK) == START_CODE) begin
			return CK_START;
		end
		return CK_NONE;
	endfunction : lsh_decode

endpackage : lsh_pkg

// ### common/lsh_bus_if.sv
`timescale 1ns/100ps
// Parallel host bus; the shared data wire is resolved from the two enables.
interface lsh_bus_if;
	logic       cd;
	logic       rw;
	logic       e;
	logic [7:0] db_h;
	logic       db_h_oe;
	logic [7:0] db_d;
	logic       db_d_oe;
	logic [7:0] db;

	// Bus level: device wins on a read, host on a write, else pulled high.
	assign db = db_d_oe ? db_d : (db_h_oe ? db_h : 8'hFF);

	modport dev (input cd, input rw, input e, input db, output db_d, output db_d_oe);
	modport host (output cd, output rw, output e, output db_h, output db_h_oe, input db);
endinterface : lsh_bus_if

// ### hdl/lsh_host.sv
`timescale 1ns/100ps
module lsh_host
	import lsh_pkg::*;
(
	// Clock and reset.
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	// Parallel bus.
	lsh_bus_if.host         bus,
	// Command port.
	input  wire logic       req_valid_i,
	output logic            req_ready_o,
	input  wire logic       req_cd_i,
	input  wire logic       req_rw_i,
	input  wire logic [7:0] req_data_i,
	output logic            rsp_valid_o,
	output logic [7:0]      rsp_data_o
);

	typedef enum logic [3:0] {
		H_IDLE  = 4'h1,
		H_SETUP = 4'h2,
		H_HIGH  = 4'h4,
		H_HOLD  = 4'h8
	} lsh_hst_t;

	typedef enum logic [1:0] {
		K_POLL,
		K_DUMMY,
		K_MAIN
	} lsh_kind_t;

	lsh_hst_t   st_q, st_d;
	lsh_kind_t  kind_q, kind_d;
	logic [3:0] cnt_q, cnt_d;
	logic       cd_q, cd_d, rw_q, rw_d;
	logic [7:0] data_q, data_d, cap_q, cap_d;
	logic       stale_q, stale_d;
	logic       rv_q, rv_d;
	logic [7:0] rd_q, rd_d;
	logic       cur_cd, cur_rw;

	// Bus control follows the step in progress; a poll is a status read.
	always_comb begin
		cur_cd = 1'b0;
		cur_rw = 1'b1;
		if (st_q != H_IDLE && kind_q == K_MAIN) begin
			cur_cd = cd_q;
			cur_rw = rw_q;
		end else if (st_q != H_IDLE && kind_q == K_DUMMY) begin
			cur_cd = 1'b1;
		end
	end

	assign bus.cd      = cur_cd;
	assign bus.rw      = cur_rw;
	assign bus.e       = (st_q == H_HIGH);
	assign bus.db_h    = data_q;
	assign bus.db_h_oe = (st_q != H_IDLE) && !cur_rw;
	assign req_ready_o = (st_q == H_IDLE);
	assign rsp_valid_o = rv_q;
	assign rsp_data_o  = rd_q;

	// Sequencer: poll busy, optional dummy read, then the requested cycle.
	always_comb begin
		st_d    = st_q;
		kind_d  = kind_q;
		cnt_d   = cnt_q;
		cd_d    = cd_q;
		rw_d    = rw_q;
		data_d  = data_q;
		cap_d   = cap_q;
		stale_d = stale_q;
		rv_d    = 1'b0;
		rd_d    = rd_q;
		case (st_q)
			H_IDLE: begin
				if (req_valid_i) begin
					cd_d   = req_cd_i;
					rw_d   = req_rw_i;
					data_d = req_data_i;
					kind_d = K_POLL;
					st_d   = H_SETUP;
				end
			end
			H_SETUP: begin
				cnt_d = 4'(STROBE_CYC - 1);
				st_d  = H_HIGH;
			end
			H_HIGH: begin
				if (cnt_q == 4'h0) begin
					cap_d = bus.db;
					st_d  = H_HOLD;
				end else begin
					cnt_d = cnt_q - 4'h1;
				end
			end
			H_HOLD: begin
				st_d = H_SETUP;
				case (kind_q)
					K_POLL: begin
						if (cap_q[ST_BUSY_BIT]) begin
							kind_d = K_POLL;
						end else if (cd_q && rw_q && stale_q) begin
							kind_d  = K_DUMMY;
							stale_d = 1'b0;
						end else begin
							kind_d = K_MAIN;
						end
					end
					K_DUMMY: begin
						kind_d = K_POLL;
					end
					default: begin
						rv_d = 1'b1;
						rd_d = cap_q;
						st_d = H_IDLE;
						// address change marks the latch stale
						if (!rw_q && (cd_q || lsh_decode(data_q) == CK_COL
								|| lsh_decode(data_q) == CK_PAGE)) begin
							stale_d = 1'b1;
						end
					end
				endcase
			end
			default: begin
				st_d = H_IDLE;
			end
		endcase
	end

	// Sequencer registers.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			st_q    <= H_IDLE;
			kind_q  <= K_POLL;
			cnt_q   <= 4'h0;
			cd_q    <= 1'b0;
			rw_q    <= 1'b1;
			data_q  <= 8'h00;
			cap_q   <= 8'h00;
			stale_q <= 1'b1;
			rv_q    <= 1'b0;
			rd_q    <= 8'h00;
		end else begin
			st_q    <= st_d;
			kind_q  <= kind_d;
			cnt_q   <= cnt_d;
			cd_q    <= cd_d;
			rw_q    <= rw_d;
			data_q  <= data_d;
			cap_q   <= cap_d;
			stale_q <= stale_d;
			rv_q    <= rv_d;
			rd_q    <= rd_d;
		end
	end

endmodule : lsh_host

// ### hdl/lsh_dev.sv
`timescale 1ns/100ps
module lsh_dev
	import lsh_pkg::*;
#(
	parameter int DEPTH = 2
) (
	// Clock and reset.
	input  wire logic              clk_i,
	input  wire logic              rst_i,
	// Parallel bus.
	lsh_bus_if.dev                 bus,
	// Display timing from the common driver.
	input  wire logic              frame_polarity_i,
	input  wire logic [5:0]        display_row_i,
	// Segment bias selects, two bits per segment.
	output logic [2*COLS-1:0]      segment_outputs_o,
	// Write buffer has room.
	output logic                   in_ready_o
);

	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);

	logic                  e_q, cd_q, rw_q;
	logic [7:0]            db_q;
	logic                  fall, push, pop;
	logic [9:0]            buf_q [DEPTH];
	logic [9:0]            buf_d [DEPTH];
	logic [PW-1:0]         wp_q, wp_d, rp_q, rp_d;
	logic [CW-1:0]         cnt_q, cnt_d;
	logic [9:0]            ent;
	logic [7:0]            mem_q [PAGES*COLS];
	logic [7:0]            mem_d [PAGES*COLS];
	logic [5:0]            col_q, col_d, start_q, start_d;
	logic [2:0]            page_q, page_d;
	logic                  on_q, on_d;
	logic [7:0]            latch_q, latch_d;
	logic [7:0]            exec_q, exec_d;
	logic [7:0]            rcnt_q, rcnt_d;
	logic                  busy, rflag;
	logic [7:0]            status, dout_q;
	logic [2*COLS-1:0]     seg_q, seg_d;

	// Bus sampling; inputs are synchronous to the clock.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			e_q  <= 1'b0;
			cd_q <= 1'b0;
			rw_q <= 1'b1;
			db_q <= 8'h00;
		end else begin
			e_q  <= bus.e;
			cd_q <= bus.cd;
			rw_q <= bus.rw;
			db_q <= bus.db;
		end
	end

	// act on the strobe falling edge
	assign fall       = e_q && !bus.e;
	assign in_ready_o = (cnt_q < CW'(DEPTH));
	// refuse while resetting or buffer full
	assign push       = fall && !(!cd_q && rw_q) && in_ready_o && !rflag;

	// reset flag held for the reset time
	assign rflag = (rcnt_q != 8'h00);
	assign busy  = rflag || (exec_q != 8'h00) || (cnt_q != '0);
	always_comb begin
		status              = 8'h00;
		status[ST_BUSY_BIT] = busy;
		// off flag inverts the on bit
		status[ST_OFF_BIT]  = !on_q;
		status[ST_RST_BIT]  = rflag;
	end

	// status on command read, latch on data read
	// drive only while strobe high on reads
	assign bus.db_d_oe = bus.e && bus.rw;
	assign bus.db_d    = dout_q;

	// Two-entry buffer between bus capture and executor.
	always_comb begin
		buf_d = buf_q;
		wp_d  = wp_q;
		rp_d  = rp_q;
		cnt_d = cnt_q;
		ent   = buf_q[rp_q];
		if (push) begin
			buf_d[wp_q] = {cd_q, rw_q, db_q};
			wp_d        = (wp_q == PW'(DEPTH - 1)) ? '0 : wp_q + PW'(1);
		end
		if (pop) begin
			rp_d = (rp_q == PW'(DEPTH - 1)) ? '0 : rp_q + PW'(1);
		end
		cnt_d = cnt_q + CW'(push) - CW'(pop);
	end

	// Executor: one buffered access per busy period.
	always_comb begin
		mem_d   = mem_q;
		col_d   = col_q;
		page_d  = page_q;
		start_d = start_q;
		on_d    = on_q;
		latch_d = latch_q;
		exec_d  = exec_q;
		rcnt_d  = rflag ? rcnt_q - 8'h01 : rcnt_q;
		pop     = 1'b0;
		if (exec_q != 8'h00) begin
			exec_d = exec_q - 8'h01;
		end else if (cnt_q != '0) begin
			pop    = 1'b1;
			exec_d = 8'(BUSY_CYC);
			if (!ent[9]) begin
				case (lsh_decode(ent[7:0]))
					CK_DISP:  on_d    = ent[0];
					CK_COL:   col_d   = ent[5:0];
					CK_PAGE:  page_d  = ent[2:0];
					CK_START: start_d = ent[5:0];
					default:  on_d    = on_q;
				endcase
			end else begin
				if (!ent[8]) begin
					// direct write at page and column
					mem_d[{page_q, col_q}] = ent[7:0];
				end else begin
					// reload latch after it was read
					latch_d = mem_q[{page_q, col_q}];
				end
				col_d = col_q + 6'h01;
			end
		end
	end

	// Segment bias select per column for the current display row.
	always_comb begin
		logic [5:0] row;
		logic [7:0] b;
		row   = start_q + display_row_i;
		b     = 8'h00;
		seg_d = '0;
		for (int s = 0; s < COLS; s++) begin
			b = mem_q[{row[5:3], 6'(s)}];
			if (!on_q) begin
				seg_d[2*s +: 2] = frame_polarity_i ? BIAS_THIRD : BIAS_SECOND;
			end else begin
				// polarity and pixel pick the level
				case ({frame_polarity_i, b[row[2:0]]})
					2'b00:   seg_d[2*s +: 2] = BIAS_SECOND;
					2'b01:   seg_d[2*s +: 2] = BIAS_TOP;
					2'b10:   seg_d[2*s +: 2] = BIAS_THIRD;
					default: seg_d[2*s +: 2] = BIAS_BOTTOM;
				endcase
			end
		end
	end
	assign segment_outputs_o = seg_q;

	// State registers.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			for (int i = 0; i < DEPTH; i++) begin
				buf_q[i] <= 10'h000;
			end
			for (int i = 0; i < PAGES * COLS; i++) begin
				mem_q[i] <= 8'h00;
			end
			wp_q    <= '0;
			rp_q    <= '0;
			cnt_q   <= '0;
			col_q   <= COL_RST;
			page_q  <= PAGE_RST;
			start_q <= START_RST;
			on_q    <= DISP_ON_RST;
			latch_q <= 8'h00;
			exec_q  <= 8'h00;
			rcnt_q  <= 8'(RESET_CYC);
			dout_q  <= 8'h00;
			seg_q   <= '0;
		end else begin
			buf_q   <= buf_d;
			mem_q   <= mem_d;
			wp_q    <= wp_d;
			rp_q    <= rp_d;
			cnt_q   <= cnt_d;
			col_q   <= col_d;
			page_q  <= page_d;
			start_q <= start_d;
			on_q    <= on_d;
			latch_q <= latch_d;
			exec_q  <= exec_d;
			rcnt_q  <= rcnt_d;
			dout_q  <= bus.cd ? latch_q : status;
			seg_q   <= seg_d;
		end
	end

endmodule : lsh_dev

// ### verif/lsh_bus_checker.sv
`timescale 1ns/100ps
module lsh_bus_checker
	import lsh_pkg::*;
(
	// Clock and reset.
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	// Bus signals.
	input  wire logic       cd,
	input  wire logic       rw,
	input  wire logic       e,
	input  wire logic [7:0] db_h,
	input  wire logic       db_h_oe,
	input  wire logic [7:0] db_d,
	input  wire logic       db_d_oe,
	input  wire logic [7:0] db
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	// A strobe pulse is four high cycles, then hold and setup low.
	sequence s_strobe_high;
		e [*4];
	endsequence
	sequence s_strobe_gap;
		!e ##1 !e;
	endsequence
	property p_strobe_width;
		$rose(e) |-> s_strobe_high ##1 s_strobe_gap;
	endproperty
	property p_ctrl_steady;
		e |-> $stable(cd) && $stable(rw);
	endproperty
	property p_wdata_steady;
		e && !rw |-> db_h_oe && $stable(db_h);
	endproperty
	property p_no_clash;
		!(db_d_oe && db_h_oe);
	endproperty
	property p_read_drive;
		db_d_oe == (e && rw) && (!db_d_oe || db == db_d);
	endproperty
	property p_status_zero;
		e && $past(e) && !cd && rw |-> (db & 8'h4F) == 8'h00;
	endproperty
	property p_reset_busy;
		e && $past(e) && !cd && rw && db[4] |-> db[7];
	endproperty
	property p_read_steady;
		e && $past(e) && $past(e, 2) && cd && rw |-> $stable(db);
	endproperty

	a_strobe_width: assert property (p_strobe_width) else $error("strobe width wrong");
	a_ctrl_steady: assert property (p_ctrl_steady) else $error("select moved");
	a_wdata_steady: assert property (p_wdata_steady) else $error("write data moved");
	a_no_clash: assert property (p_no_clash) else $error("bus driven twice");
	a_read_drive: assert property (p_read_drive) else $error("read drive wrong");
	a_status_zero: assert property (p_status_zero) else $error("status pad bit set");
	a_reset_busy: assert property (p_reset_busy) else $error("reset without busy");
	a_read_steady: assert property (p_read_steady) else $error("read data moved");
endmodule : lsh_bus_checker

// ### verif/testbench.sv
`timescale 1ns/100ps
module testbench
	import lsh_pkg::*;
;
	typedef struct packed {
		logic       cd;
		logic       rw;
		logic [7:0] data;
		logic [7:0] mask;
		logic [7:0] exp;
	} lsh_row_t;

	logic                 clk_i;
	logic                 rst_i;
	logic                 req_valid_i;
	logic                 req_ready_o;
	logic                 req_cd_i;
	logic                 req_rw_i;
	logic [7:0]           req_data_i;
	logic                 rsp_valid_o;
	logic [7:0]           rsp_data_o;
	logic                 frame_polarity_i;
	logic [5:0]           display_row_i;
	logic [2*COLS-1:0]    segment_outputs_o;
	logic                 in_ready_o;
	logic [7:0]           got;
	int                   mismatches;
	int                   checks_done;
	int                   cycles;
	int                   t0;
	lsh_row_t             rows [20];

	lsh_bus_if bus_if ();
	lsh_host lsh_host_inst (.clk_i(clk_i), .rst_i(rst_i), .bus(bus_if.host),
		.req_valid_i(req_valid_i), .req_ready_o(req_ready_o), .req_cd_i(req_cd_i),
		.req_rw_i(req_rw_i), .req_data_i(req_data_i), .rsp_valid_o(rsp_valid_o),
		.rsp_data_o(rsp_data_o));
	lsh_dev #(.DEPTH(2)) lsh_dev_inst (.clk_i(clk_i), .rst_i(rst_i), .bus(bus_if.dev),
		.frame_polarity_i(frame_polarity_i), .display_row_i(display_row_i),
		.segment_outputs_o(segment_outputs_o), .in_ready_o(in_ready_o));
	lsh_bus_checker lsh_bus_checker_inst (.clk_i(clk_i), .rst_i(rst_i), .cd(bus_if.cd),
		.rw(bus_if.rw), .e(bus_if.e), .db_h(bus_if.db_h), .db_h_oe(bus_if.db_h_oe),
		.db_d(bus_if.db_d), .db_d_oe(bus_if.db_d_oe), .db(bus_if.db));

	task automatic final_report();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : final_report

	task automatic cmp_byte(input string nm, input logic [7:0] ex, input logic [7:0] sn);
		checks_done++;
		if (sn !== ex) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", nm, ex, sn);
		end
	endtask : cmp_byte

	task automatic cmp_seg(input string nm, input logic [1:0] ex, input logic [1:0] sn);
		checks_done++;
		if (sn !== ex) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", nm, ex, sn);
		end
	endtask : cmp_seg

	// One request through the host port; waits for its response pulse.
	task automatic do_req(input lsh_row_t r, output logic [7:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		#1;
		req_cd_i = r.cd;
		req_rw_i = r.rw;
		req_data_i = r.data;
		req_valid_i = 1'b1;
		@(posedge clk_i);
		#1;
		req_valid_i = 1'b0;
		while (rsp_valid_o !== 1'b1 && n < 3000) begin
			@(posedge clk_i);
			#1;
			n++;
		end
		if (n == 3000) begin
			mismatches++;
		end
		d = rsp_data_o;
		cmp_byte("ready", 8'h01, {7'h00, req_ready_o});
	endtask : do_req

	// Sets the polarity and checks the bias codes of columns 0 and 1.
	task automatic seg_check(input logic pol, input logic [1:0] e0, input logic [1:0] e1);
		@(posedge clk_i);
		#1;
		frame_polarity_i = pol;
		repeat (8) @(posedge clk_i);
		#1;
		cmp_seg("seg col0", e0, segment_outputs_o[1:0]);
		cmp_seg("seg col1", e1, segment_outputs_o[3:2]);
	endtask : seg_check

	// Free-running clock.
	initial begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end

	// Hang guard.
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 30000) begin
			mismatches++;
			final_report();
		end
	end

	// Main sequence.
	initial begin
		{req_valid_i, req_cd_i, req_rw_i, req_data_i, frame_polarity_i} = '0;
		{mismatches, checks_done, cycles} = '0;
		display_row_i = 6'h0B;
		rst_i = 1'b1;
		rows = '{'{0, 1, 8'h00, 8'h7F, 8'h20}, '{0, 0, 8'hBA, 8'h00, 8'h00},
			'{0, 0, 8'h7F, 8'h00, 8'h00}, '{1, 0, 8'hA5, 8'h00, 8'h00},
			'{1, 0, 8'h5A, 8'h00, 8'h00}, '{1, 0, 8'hC3, 8'h00, 8'h00},
			'{0, 0, 8'h7F, 8'h00, 8'h00}, '{1, 1, 8'h00, 8'hFF, 8'hA5},
			'{1, 1, 8'h00, 8'hFF, 8'h5A}, '{0, 0, 8'h22, 8'h00, 8'h00},
			'{0, 0, 8'hC5, 8'h00, 8'h00}, '{1, 1, 8'h00, 8'hFF, 8'hC3},
			'{0, 0, 8'hB9, 8'h00, 8'h00}, '{0, 0, 8'h40, 8'h00, 8'h00},
			'{1, 1, 8'h00, 8'hFF, 8'h00}, '{0, 0, 8'hBA, 8'h00, 8'h00},
			'{0, 0, 8'h41, 8'h00, 8'h00}, '{1, 1, 8'h00, 8'hFF, 8'hC3},
			'{0, 0, 8'h3F, 8'h00, 8'h00}, '{0, 1, 8'h00, 8'h7F, 8'h00}};
		repeat (4) @(posedge clk_i);
		#1;
		rst_i = 1'b0;
		repeat (RESET_CYC + 10) @(posedge clk_i);
		foreach (rows[i]) begin
			do_req(rows[i], got);
			cmp_byte("table", rows[i].exp, got & rows[i].mask);
		end
		$display("test table done");
		seg_check(1'b0, BIAS_SECOND, BIAS_TOP);
		seg_check(1'b1, BIAS_THIRD, BIAS_BOTTOM);
		$display("test bias on done");
		do_req('{0, 0, 8'h3E, 8'h00, 8'h00}, got);
		do_req('{0, 1, 8'h00, 8'h00, 8'h00}, got);
		cmp_byte("status off", 8'h20, got & 8'h7F);
		seg_check(1'b0, BIAS_SECOND, BIAS_SECOND);
		seg_check(1'b1, BIAS_THIRD, BIAS_THIRD);
		cmp_byte("buffer room", 8'h01, {7'h00, in_ready_o});
		$display("test bias off done");
		// Mid-run reset: the host polls through the reset flag before it may read.
		@(posedge clk_i);
		#1;
		rst_i = 1'b1;
		repeat (4) @(posedge clk_i);
		#1;
		rst_i = 1'b0;
		t0 = cycles;
		do_req('{0, 1, 8'h00, 8'h00, 8'h00}, got);
		cmp_byte("status after reset", 8'h20, got);
		cmp_byte("reset wait", 8'h01, {7'h00, (cycles - t0) >= RESET_CYC});
		$display("test reset done");
		final_report();
	end
endmodule : testbench
